/* common/accm_map.svh */
// Register map, field positions, reset values and timing counts
`ifndef ACCM_MAP_SVH
`define ACCM_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ACCM_CFG_BASE 12'h000
`define ACCM_CTRL_OFS 12'h040
`define ACCM_OFFSET_OFS 12'h044
`define ACCM_GAIN_OFS 12'h048
`define ACCM_STATUS_OFS 12'h04C

// ****************************************************************
// Field positions
// ****************************************************************
`define ACCM_CFG_PAIR_LSB 0
`define ACCM_CFG_MODE_BIT 2
`define ACCM_CFG_OSR_LSB 4
`define ACCM_CTRL_SEQ_LSB 0
`define ACCM_ST_CHAN_LSB 0
`define ACCM_ST_CLOSED_BIT 5
`define ACCM_ST_BUSY_BIT 6
`define ACCM_ST_BIPOLAR_BIT 7

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define ACCM_CFG_RESET 6'h00
`define ACCM_GAIN_RESET 16'h8000
`define ACCM_OFFSET_RESET 16'h0000
`define ACCM_TEMP_CHAN 5'h10
`define ACCM_MID_19 19'h4_0000
`define ACCM_MAX_19 19'h7_FFFF

// ****************************************************************
// Timing
// ****************************************************************
`define ACCM_CLK_NS 10
`define ACCM_BBM_GAP_NS 10
`define ACCM_BBM_CYCLES ((`ACCM_BBM_GAP_NS + `ACCM_CLK_NS - 1) / `ACCM_CLK_NS)

`endif

/* common/accm_pkg.sv */
// Types shared by the channel configuration and mux control block
package accm_pkg;
    typedef enum logic [1:0] {
        ACCM_PAIR_GND = 2'b00,
        ACCM_PAIR_COM = 2'b01,
        ACCM_PAIR_EVEN_ODD = 2'b10,
        ACCM_PAIR_SPARE = 2'b11
    } accm_pair_e;

    typedef enum logic [1:0] {
        ACCM_SEQ_STANDARD = 2'b00,
        ACCM_SEQ_ADVANCED = 2'b01,
        ACCM_SEQ_TWO_CYCLE = 2'b10,
        ACCM_SEQ_ONE_CYCLE = 2'b11
    } accm_seq_e;

    typedef enum logic [1:0] {
        ACCM_MUX_OPEN = 2'b00,
        ACCM_MUX_BREAK = 2'b01,
        ACCM_MUX_CLOSED = 2'b10
    } accm_mux_e;

    typedef logic [5:0] accm_cfg_t;
endpackage

/* rtl/accm_top.sv */
// Channel configuration, mux switch control and result formatting
//
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "accm_map.svh"

module accm_top
    import accm_pkg::*;
#(
    parameter int N_IN = 16,
    parameter int CORE_W = 16,
    parameter int RES_W = 19
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic hsel_in,
    input wire logic [11:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic sel_valid_in,
    input wire logic [4:0] sel_chan_in,
    input wire logic core_valid_in,
    input wire logic [CORE_W-1:0] core_code_in,
    output logic [N_IN:0] pos_switch_out,
    output logic [N_IN/2+1:0] neg_switch_out,
    output logic [4:0] active_chan_out,
    output logic bipolar_out,
    output logic [RES_W-1:0] result_out,
    output logic [4:0] result_bits_out,
    output logic result_valid_out
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        // Register file
        logic [N_IN-1:0][5:0] cfg;
        logic [1:0] seq;
        logic [15:0] offset;
        logic [15:0] gain;
        // Bus pipeline
        logic dp_act;
        logic dp_write;
        logic [11:0] dp_addr;
        logic [31:0] rdata;
        logic ready;
        // Mux control and selected channel
        accm_mux_e mux;
        logic [3:0] gap_cnt;
        logic [4:0] chan;
        logic [1:0] oversampling_ratio;
        logic bipolar;
        logic [N_IN:0] pos_sw;
        logic [N_IN/2+1:0] neg_sw;
        // Averaging and result
        logic [21:0] sum;
        logic [6:0] cnt;
        logic [RES_W-1:0] result;
        logic [4:0] rbits;
        logic rvalid;
    } accm_state_s;

    accm_state_s state_reg;
    accm_state_s state_next;

    // ****************************************************************
    // Channel resolution
    // ****************************************************************
    // Resolved settings per input, one copy per channel
    logic [N_IN-1:0][1:0] eff_pair;
    logic [N_IN-1:0] eff_bip;

    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi++) begin : g_res
            logic [1:0] raw_pair;
            // Standard sequencer takes pairing from input zero
            assign raw_pair = (state_reg.seq == ACCM_SEQ_STANDARD) ?
                state_reg.cfg[0][1:0] : state_reg.cfg[gi][1:0];
            // Spare code behaves as reference ground; an odd input has
            // no higher partner, so its own even/odd code is ground too
            assign eff_pair[gi] = (raw_pair == ACCM_PAIR_SPARE ||
                (gi % 2 == 1 && raw_pair == ACCM_PAIR_EVEN_ODD)) ?
                ACCM_PAIR_GND : raw_pair;
            // Polarity always own; ground pairing forces unipolar
            assign eff_bip[gi] = state_reg.cfg[gi][`ACCM_CFG_MODE_BIT] &&
                (eff_pair[gi] != ACCM_PAIR_GND);
        end
    endgenerate

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    // Word map, byte offsets, whole 32-bit words only:
    //   0x00 + 4*i  input i: [1:0] pairing, [2] polarity, [5:4] ratio
    //   0x40        sequencing mode in [1:0]
    //   0x44        signed offset, added in result units
    //   0x48        gain, 0x8000 is unity
    //   0x4C        status, read-only
    //   status: [4:0] chan, [5] closed, [6] busy, [7] bipolar
    //   elsewhere   reads zero, writes dropped, still OKAY
    // Register hits, one flag per register; ap_cfg covers all input words
    logic ap_take;
    logic ap_cfg;
    logic ap_ctrl;
    logic ap_ofs;
    logic ap_gain;
    logic ap_stat;
    logic dp_wr;
    logic dp_cfg;
    logic dp_ctrl;
    logic dp_ofs;
    logic dp_gain;

    // Address phase taken; a low hready holds it off
    assign ap_take = hsel_in && htrans_in[1] && hready_in;

    // Register hit of the address phase
    assign ap_cfg = haddr_in[11:6] == 6'h00;
    assign ap_ctrl = haddr_in[11:2] == `ACCM_CTRL_OFS >> 2;
    assign ap_ofs = haddr_in[11:2] == `ACCM_OFFSET_OFS >> 2;
    assign ap_gain = haddr_in[11:2] == `ACCM_GAIN_OFS >> 2;
    assign ap_stat = haddr_in[11:2] == `ACCM_STATUS_OFS >> 2;

    // Same hits except status for the write data phase, from the latched address
    assign dp_wr = state_reg.dp_act && state_reg.dp_write;
    assign dp_cfg = state_reg.dp_addr[11:6] == 6'h00;
    assign dp_ctrl = state_reg.dp_addr[11:2] == `ACCM_CTRL_OFS >> 2;
    assign dp_ofs = state_reg.dp_addr[11:2] == `ACCM_OFFSET_OFS >> 2;
    assign dp_gain = state_reg.dp_addr[11:2] == `ACCM_GAIN_OFS >> 2;

    // Status flags; busy means a partial sum is held
    logic st_busy;
    logic st_closed;
    assign st_busy = state_reg.cnt != 7'h00;
    assign st_closed = state_reg.mux == ACCM_MUX_CLOSED;

    // ****************************************************************
    // Result format
    // ****************************************************************
    // Width-dependent limits of the selected ratio
    logic [18:0] fmt_max;
    logic [18:0] fmt_msb;
    logic [6:0] fmt_need;
    assign fmt_max = `ACCM_MAX_19 >> (2'd3 - state_reg.oversampling_ratio);
    assign fmt_msb = `ACCM_MID_19 >> (2'd3 - state_reg.oversampling_ratio);
    // Codes per result: four to the power of the ratio code
    assign fmt_need = 7'h01 << {state_reg.oversampling_ratio, 1'b0};

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        logic [4:0] req;
        logic [3:0] idx;
        logic [3:0] src;
        logic [3:0] word;
        logic [18:0] avg;
        logic [34:0] prod;
        logic signed [22:0] corr;
        logic [18:0] code;
        req = sel_chan_in;
        idx = sel_chan_in[3:0];
        src = idx;
        word = state_reg.dp_addr[5:2];
        avg = 19'h0_0000;
        prod = 35'h0_0000_0000;
        corr = 23'sh00_0000;
        code = 19'h0_0000;
        state_next = state_reg;
        state_next.rvalid = 1'b0;
        state_next.ready = 1'b1;

        // Bus data phase: write lands, read was staged earlier
        // Unmapped words and status drop the write
        if (dp_wr) begin
            if (dp_cfg) begin
                state_next.cfg[word] = hwdata_in[5:0];
            end else if (dp_ctrl) begin
                state_next.seq = hwdata_in[1:0];
            end else if (dp_ofs) begin
                state_next.offset = hwdata_in[15:0];
            end else if (dp_gain) begin
                state_next.gain = hwdata_in[15:0];
            end
        end

        // Address phase: latch request, stage read data now
        state_next.dp_act = 1'b0;
        if (ap_take) begin
            state_next.dp_act = 1'b1;
            state_next.dp_write = hwrite_in;
            state_next.dp_addr = {haddr_in[11:2], 2'b00};
            state_next.rdata = 32'h0000_0000;
            if (!hwrite_in) begin
                if (ap_cfg) begin
                    state_next.rdata = {26'h000_0000,
                        state_reg.cfg[haddr_in[5:2]]};
                end else if (ap_ctrl) begin
                    state_next.rdata = {30'h0000_0000, state_reg.seq};
                end else if (ap_ofs) begin
                    state_next.rdata = {16'h0000, state_reg.offset};
                end else if (ap_gain) begin
                    state_next.rdata = {16'h0000, state_reg.gain};
                end else if (ap_stat) begin
                    state_next.rdata = {24'h00_0000, state_reg.bipolar,
                        st_busy, st_closed, state_reg.chan};
                end
            end
        end

        // Odd member of an even/odd pair folds onto the even input
        // The odd member is still accepted, only resolved
        if (!req[4] && idx[0] && eff_pair[{idx[3:1], 1'b0}] ==
            ACCM_PAIR_EVEN_ODD) begin
            src = {idx[3:1], 1'b0};
        end

        // Break-before-make switch sequencing; closing in the breaking
        // edge would join the old and new inputs for a cycle
        // Negative bits: 0 ground, 1 common pin, 2+k odd input 2k+1
        unique case (state_reg.mux)
            ACCM_MUX_OPEN: begin
                state_next.pos_sw = '0;
                state_next.neg_sw = '0;
            end
            ACCM_MUX_BREAK: begin
                state_next.gap_cnt = state_reg.gap_cnt - 4'h1;
                if (state_reg.gap_cnt == 4'h1) begin
                    state_next.mux = ACCM_MUX_CLOSED;
                    if (state_reg.chan[4]) begin
                        // Temperature sensor against reference ground
                        state_next.pos_sw[N_IN] = 1'b1;
                        state_next.neg_sw[0] = 1'b1;
                    end else begin
                        state_next.pos_sw[state_reg.chan[3:0]] = 1'b1;
                        unique case (eff_pair[state_reg.chan[3:0]])
                            ACCM_PAIR_COM: state_next.neg_sw[1] = 1'b1;
                            ACCM_PAIR_EVEN_ODD:
                                state_next.neg_sw[
                                    2 + state_reg.chan[3:1]] = 1'b1;
                            default: state_next.neg_sw[0] = 1'b1;
                        endcase
                    end
                end
            end
            ACCM_MUX_CLOSED: begin
            end
            // Unused code after an upset: open all, wait for a select
            default: begin
                state_next.mux = ACCM_MUX_OPEN;
                state_next.pos_sw = '0;
                state_next.neg_sw = '0;
            end
        endcase

        // New selection opens every switch first
        if (sel_valid_in) begin
            state_next.mux = ACCM_MUX_BREAK;
            state_next.gap_cnt = 4'(`ACCM_BBM_CYCLES);
            state_next.pos_sw = '0;
            state_next.neg_sw = '0;
            state_next.sum = 22'h00_0000;
            state_next.cnt = 7'h00;
            if (req[4]) begin
                state_next.chan = `ACCM_TEMP_CHAN;
                state_next.oversampling_ratio = 2'b00;
                state_next.bipolar = 1'b0;
            end else begin
                // Even input's register governs the pair
                state_next.chan = {1'b0, src};
                state_next.oversampling_ratio = state_reg.cfg[src][5:4];
                state_next.bipolar = eff_bip[src];
            end
        end else if (core_valid_in && state_reg.mux == ACCM_MUX_CLOSED) begin
            // Average the core codes, then correct and format
            if (state_reg.cnt + 7'h01 == fmt_need) begin
                avg = 19'((state_reg.sum + 22'(core_code_in)) >>
                    state_reg.oversampling_ratio);
                prod = 35'(avg) * 35'(state_reg.gain);
                corr = $signed({3'b000, prod[34:15]}) +
                    23'($signed(state_reg.offset));
                // Clamp before the flip, so a code can never wrap
                if (corr < 0) begin
                    code = 19'h0_0000;
                end else if (corr > $signed({4'h0, fmt_max})) begin
                    code = fmt_max;
                end else begin
                    code = corr[18:0];
                end
                // Twos complement is straight binary with top bit flipped
                if (state_reg.bipolar) begin
                    code = code ^ fmt_msb;
                end
                state_next.result = code;
                state_next.rbits = 5'(CORE_W) + {3'b000, state_reg.oversampling_ratio};
                state_next.rvalid = 1'b1;
                state_next.sum = 22'h00_0000;
                state_next.cnt = 7'h00;
            end else begin
                state_next.sum = state_reg.sum + 22'(core_code_in);
                state_next.cnt = state_reg.cnt + 7'h01;
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Reset state: unity gain, zero offset, switches open
    // Offset and gain are shared by every input, not per input
    // Low ce_in freezes the bus too; hready keeps its level
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= '0;
            state_reg.gain <= `ACCM_GAIN_RESET;
            state_reg.offset <= `ACCM_OFFSET_RESET;
            state_reg.mux <= ACCM_MUX_OPEN;
        end else if (ce_in) begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Outputs taken straight from state flops, except hresp_out, which is tied low
    assign hrdata_out = state_reg.rdata;
    assign hreadyout_out = state_reg.ready;
    assign hresp_out = 1'b0;
    assign pos_switch_out = state_reg.pos_sw;
    assign neg_switch_out = state_reg.neg_sw;
    assign active_chan_out = state_reg.chan;
    assign bipolar_out = state_reg.bipolar;
    assign result_out = state_reg.result;
    assign result_bits_out = state_reg.rbits;
    assign result_valid_out = state_reg.rvalid;

endmodule // accm_top

/* bench/accm_top_asserts.sv */
// Port-level checks for the channel mux and result path
`timescale 1ns/1ps
module accm_top_asserts #(
    parameter int N_IN = 16,
    parameter int RES_W = 19
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic sel_valid_in,
    input wire logic core_valid_in,
    input wire logic hresp_out,
    input wire logic [N_IN:0] pos_switch_out,
    input wire logic [N_IN/2+1:0] neg_switch_out,
    input wire logic [4:0] active_chan_out,
    input wire logic bipolar_out,
    input wire logic [RES_W-1:0] result_out,
    input wire logic [4:0] result_bits_out,
    input wire logic result_valid_out
);
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    AST_BUS_OKAY: assert property (
        hresp_out == 1'b0) else $error("bus response not okay");
    AST_BBM_BREAK: assert property (
        sel_valid_in && ce_in |=> pos_switch_out == '0
        && neg_switch_out == '0) else $error("switches not opened");
    AST_BBM_MAKE: assert property (
        sel_valid_in && ce_in ##1 ce_in && !sel_valid_in |=>
        $onehot(pos_switch_out) && $onehot(neg_switch_out))
        else $error("switches not closed after gap");
    AST_SW_HOLD: assert property (
        pos_switch_out != '0 && !sel_valid_in && ce_in |=>
        $stable(pos_switch_out) && $stable(neg_switch_out))
        else $error("closed switches moved");
    AST_POS_ACTIVE: assert property (
        pos_switch_out != '0 && !pos_switch_out[N_IN] |->
        pos_switch_out == ((N_IN+1)'(1) << active_chan_out))
        else $error("positive switch differs from channel");
    AST_PAIR_NEG: assert property (
        pos_switch_out != '0 && neg_switch_out[N_IN/2+1:2] != '0 |->
        !active_chan_out[0] && neg_switch_out ==
        ((N_IN/2+2)'(1) << (active_chan_out[3:1] + 2)))
        else $error("pair negative switch wrong");
    AST_GND_UNI: assert property (
        pos_switch_out != '0 && neg_switch_out[0] |-> !bipolar_out)
        else $error("bipolar with ground pairing");
    AST_TEMP: assert property (
        pos_switch_out[N_IN] |-> active_chan_out[4] && !bipolar_out
        && neg_switch_out == (N_IN/2+2)'(1))
        else $error("temperature routing wrong");
    AST_RES_CAUSE: assert property (
        result_valid_out |-> $past(core_valid_in && ce_in))
        else $error("result without a core code");
    AST_RES_WIDTH: assert property (
        result_valid_out |-> result_bits_out >= 5'd16
        && result_bits_out <= 5'd19 && (result_out >> result_bits_out) == '0)
        else $error("result wider than its width");

    // Main scenarios reached
    cover property (sel_valid_in ##2 pos_switch_out[N_IN]);
    cover property (result_valid_out && result_bits_out == 5'd19);
    cover property (neg_switch_out[N_IN/2+1:2] != '0);
endmodule // accm_top_asserts

bind accm_top accm_top_asserts #(.N_IN(N_IN), .RES_W(RES_W)) u_chk (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .sel_valid_in(sel_valid_in), .core_valid_in(core_valid_in),
    .hresp_out(hresp_out), .pos_switch_out(pos_switch_out),
    .neg_switch_out(neg_switch_out), .active_chan_out(active_chan_out),
    .bipolar_out(bipolar_out), .result_out(result_out),
    .result_bits_out(result_bits_out), .result_valid_out(result_valid_out));

/* bench/test_adc_channel_config_mux_control.sv */
// Register-driven tests of channel resolution, switches and results
`timescale 1ns/1ps
module test_adc_channel_config_mux_control;
    logic core_clk_in, rst_in, hsel_in, hwrite_in;
    logic sel_valid_in, core_valid_in;
    logic hreadyout_out, hresp_out, bipolar_out, result_valid_out;
    logic [11:0] haddr_in;
    logic [1:0] htrans_in;
    logic [31:0] hwdata_in, hrdata_out, rd;
    logic [4:0] sel_chan_in, active_chan_out, result_bits_out;
    logic [15:0] core_code_in;
    logic [16:0] pos_switch_out;
    logic [9:0] neg_switch_out;
    logic [18:0] result_out;
    int err_count, checked;
    // Ratio 64 rows: code, offset, polarity, expected result
    logic [15:0] codes [5] = '{16'h8000, 16'hFFFF, 16'h8000, 16'h0, 16'h8000};
    logic [15:0] ofs [5] = '{16'h0, 16'h7, 16'h0, 16'h0, 16'hFFFF};
    logic bips [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    logic [18:0] exps [5] = '{19'h4_0000, 19'h7_FFFF, 19'h0, 19'h4_0000,
        19'h7_FFFF};

    // Slave is alone on the bus, so its ready is the bus ready
    accm_top u_accm_top (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .ce_in(1'b1), .hsel_in(hsel_in), .haddr_in(haddr_in),
        .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'b010),
        .hwdata_in(hwdata_in), .hready_in(hreadyout_out),
        .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
        .hresp_out(hresp_out), .sel_valid_in(sel_valid_in),
        .sel_chan_in(sel_chan_in), .core_valid_in(core_valid_in),
        .core_code_in(core_code_in), .pos_switch_out(pos_switch_out),
        .neg_switch_out(neg_switch_out), .active_chan_out(active_chan_out),
        .bipolar_out(bipolar_out), .result_out(result_out),
        .result_bits_out(result_bits_out),
        .result_valid_out(result_valid_out));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    always #5 core_clk_in = ~core_clk_in;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task end_sim;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // One single-word transfer; the master never assumes a wait count
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge core_clk_in);
        hsel_in <= 1'b1;
        haddr_in <= a;
        hwrite_in <= w;
        htrans_in <= 2'b10;
        do @(posedge core_clk_in); while (hreadyout_out !== 1'b1);
        htrans_in <= 2'b00;
        hwdata_in <= d;
        do @(posedge core_clk_in); while (hreadyout_out !== 1'b1);
        q = hrdata_out;
    endtask

    // Select, then check the open gap and the closed routing
    task sel(input logic [4:0] ch, input logic [4:0] act, input int pb,
        input int nb, input logic bip);
        @(posedge core_clk_in);
        sel_valid_in <= 1'b1;
        sel_chan_in <= ch;
        @(posedge core_clk_in);
        sel_valid_in <= 1'b0;
        #1;
        chk({15'h0, pos_switch_out}, 32'h0);
        chk({22'h0, neg_switch_out}, 32'h0);
        @(posedge core_clk_in);
        #1;
        chk({15'h0, pos_switch_out}, 32'h1 << pb);
        chk({22'h0, neg_switch_out}, 32'h1 << nb);
        chk({27'h0, active_chan_out}, {27'h0, act});
        chk({31'h0, bipolar_out}, {31'h0, bip});
    endtask

    // Back-to-back core codes, then look for the one result pulse
    task feed(input int n, input logic [15:0] code, input logic [18:0] exp,
        input logic [4:0] bits);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge core_clk_in);
            core_valid_in <= 1'b1;
            core_code_in <= code;
        end
        @(posedge core_clk_in);
        core_valid_in <= 1'b0;
        repeat (3) begin
            #1;
            if (result_valid_out === 1'b1 && !seen) begin
                seen = 1'b1;
                chk({13'h0, result_out}, {13'h0, exp});
                chk({27'h0, result_bits_out}, {27'h0, bits});
            end
            @(posedge core_clk_in);
        end
        chk({31'h0, seen}, 32'h1);
    endtask

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        core_clk_in = 1'b0;
        rst_in = 1'b1;
        {hsel_in, hwrite_in, sel_valid_in, core_valid_in} = 4'h0;
        {haddr_in, htrans_in, hwdata_in} = '0;
        {sel_chan_in, core_code_in} = '0;
        repeat (10) @(posedge core_clk_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        xfer(1'b0, 12'h048, 32'h0, rd);
        chk(rd, 32'h0000_8000);
        xfer(1'b1, 12'h080, 32'h5, rd);
        xfer(1'b0, 12'h080, 32'h0, rd);
        chk(rd, 32'h0);
        // Standard mode: input zero pairing wins over input two
        xfer(1'b1, 12'h000, 32'h2, rd);
        xfer(1'b1, 12'h008, 32'h0, rd);
        sel(5'd3, 5'd2, 2, 3, 1'b0);
        // Other modes: each input its own pairing
        xfer(1'b1, 12'h040, 32'h1, rd);
        xfer(1'b1, 12'h008, 32'h1, rd);
        sel(5'd3, 5'd3, 3, 0, 1'b0);
        xfer(1'b1, 12'h010, 32'h2, rd);
        sel(5'd5, 5'd4, 4, 4, 1'b0);
        sel(5'd4, 5'd4, 4, 4, 1'b0);
        xfer(1'b1, 12'h018, 32'h7, rd);
        sel(5'd6, 5'd6, 6, 0, 1'b0);
        xfer(1'b1, 12'h020, 32'h5, rd);
        sel(5'd8, 5'd8, 8, 1, 1'b1);
        sel(5'h10, 5'h10, 16, 0, 1'b0);
        // Status: closed, temperature channel, unipolar, idle
        xfer(1'b0, 12'h04C, 32'h0, rd);
        chk(rd, 32'h0000_0030);
        // Standard mode again: shared pairing, own polarity
        xfer(1'b1, 12'h040, 32'h0, rd);
        xfer(1'b1, 12'h000, 32'h1, rd);
        xfer(1'b1, 12'h024, 32'h4, rd);
        sel(5'd9, 5'd9, 9, 1, 1'b1);
        // Two-cycle mode: input nine's own ground pairing, so unipolar
        xfer(1'b1, 12'h040, 32'h2, rd);
        sel(5'd9, 5'd9, 9, 0, 1'b0);
        for (int i = 0; i < 5; i++) begin
            xfer(1'b1, 12'h020, {26'h0, 3'b110, bips[i], 2'b01}, rd);
            xfer(1'b1, 12'h044, {16'h0, ofs[i]}, rd);
            sel(5'd8, 5'd8, 8, 1, bips[i]);
            feed(64, codes[i], exps[i], 5'd19);
        end
        // Single-cycle mode: input six keeps its own spare code
        xfer(1'b1, 12'h040, 32'h3, rd);
        sel(5'd6, 5'd6, 6, 0, 1'b0);
        xfer(1'b1, 12'h020, 32'h1, rd);
        xfer(1'b1, 12'h044, 32'h0, rd);
        sel(5'd8, 5'd8, 8, 1, 1'b0);
        feed(1, 16'h1234, 19'h1234, 5'd16);
        end_sim;
    end

    // Hang guard, far beyond the roughly 500 cycles the tests need
    initial begin
        repeat (20000) @(posedge core_clk_in);
        err_count++;
        end_sim;
    end
endmodule // test_adc_channel_config_mux_control
